// ---- rpmpe_ctrl.sv ----
// reset detection, serial programming entry, power modes and pin control
`timescale 1ns/1ps
`include "rpmpe_cfg.svh"

// Overview of operation
// RULE1 - reset pin high for two machine cycles with oscillator running resets device
// RULE2 - after reset a ten-bit key on reset pin, lsb first, enters programming
// RULE3 - programmer presents each key bit in step with the crystal input
// RULE4 - in programming, eleven-bit address arrives on port 3 in two parts
// RULE5 - select low gives low address byte, high gives three high bits
// RULE6 - port 1 drives read data in verify, takes write data in program
// RULE7 - programmer drives select high for verify, low for program
// RULE8 - analog pins are outputs only while converter is disabled
// RULE9 - crystal clock passes a divide-by-two stage before internal clocking
// RULE10 - idle or power-down starts only after the requesting instruction completes
// RULE11 - idle stops cpu, converter and pwm; timers and interrupts keep running
// RULE12 - idle holds cpu state, ram and special registers unchanged
// RULE13 - enabled interrupt or hardware reset leaves idle
// RULE14 - software waits for analog references to settle before converting
// RULE15 - power-down stops oscillator and keeps only ram
// RULE16 - only hardware reset leaves power-down, interrupts do not
// RULE17 - ports keep driving latched data in idle and power-down, except pwm pin; the code drives the pwm pin from its latch as well
// RULE18 - key mismatch after ten bits returns to normal operation
module rpmpe_ctrl #(
	parameter int MC_OSC = `RPMPE_MC_OSC,
	parameter int RST_MC = `RPMPE_RST_MC,
	parameter int KEY_BITS = `RPMPE_KEY_BITS,
	parameter logic [`RPMPE_KEY_BITS-1:0] KEY = `RPMPE_KEY
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// device pins
	input wire logic reset_pin,
	input wire logic crystal_input,
	input wire logic address_byte_select,
	input wire logic verify_program_select,
	input wire logic [7:0] port1_in,
	input wire logic [7:0] port3_in,
	// core side
	input wire logic idle_req,
	input wire logic pdown_req,
	input wire logic instr_done,
	input wire logic irq_wake,
	input wire logic adc_enable,
	input wire logic pwm_sel,
	input wire logic pwm_value,
	input wire logic [4:0] port0_latch,
	input wire logic [7:0] port1_latch,
	input wire logic [7:0] port3_latch,
	input wire logic [7:0] mem_rd_data,
	// mode and clock control
	output logic dev_reset_q,
	output logic prog_state_q,
	output logic osc_run_q,
	output logic clk_half_en_q,
	output logic cpu_run_q,
	output logic adc_pwm_run_q,
	output logic tmr_irq_run_q,
	output logic vector_go_q,
	// program memory access
	output logic [`RPMPE_ADDR_BITS-1:0] mem_addr_q,
	output logic [7:0] mem_wr_data_q,
	output logic mem_wr_q,
	// port pins
	output logic [4:0] port0_out_q,
	output logic [4:0] port0_oe_q,
	output logic [7:0] port1_out_q,
	output logic [7:0] port1_oe_q,
	output logic [7:0] port3_out_q,
	output logic [7:0] port3_oe_q
);
	localparam int RST_N = MC_OSC * RST_MC;
	localparam int CW = $clog2(RST_N + 1);
	localparam int BW = $clog2(KEY_BITS + 1);

	if (RST_N < 2 || KEY_BITS != `RPMPE_KEY_BITS) begin : g_bad_cfg
		$error("rpmpe_ctrl: unsupported reset length or key width");
	end

	rpmpe_pkg::rpmpe_state_t st_q;
	rpmpe_pkg::rpmpe_state_t st_d;
	logic rst_s;
	logic xtal_s;
	logic xtal_prev_q;
	logic abs_s;
	logic vps_s;
	logic vps_prev_q;
	logic [7:0] p1_s;
	logic [7:0] p3_s;
	logic [CW-1:0] rst_cnt_q;
	logic [KEY_BITS-1:0] shift_q;
	logic [BW-1:0] bit_cnt_q;

	rpmpe_sync #(.WIDTH(20)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_in({reset_pin, crystal_input, address_byte_select, verify_program_select, port1_in, port3_in}),
		.sync_out({rst_s, xtal_s, abs_s, vps_s, p1_s, p3_s})
	);

	wire xtal_rise = xtal_s & ~xtal_prev_q;
	wire rst_count_ok = osc_run_q | (st_q == rpmpe_pkg::ST_PDOWN);
	// RULE1 reset length check
	wire rst_fire = rst_s & rst_count_ok & (rst_cnt_q == CW'(RST_N - 1));
	wire last_bit = xtal_rise & (bit_cnt_q == BW'(KEY_BITS - 1));
	wire [KEY_BITS-1:0] key_word = {rst_s, shift_q[KEY_BITS-1:1]};
	wire key_match = key_word == KEY;
	wire in_prog = st_q == rpmpe_pkg::ST_PROG;
	wire in_lowpwr = (st_q == rpmpe_pkg::ST_IDLE) | (st_q == rpmpe_pkg::ST_PDOWN);
	wire wake_irq = (st_q == rpmpe_pkg::ST_IDLE) & irq_wake & ~rst_fire;
	// RULE8 analog pin direction
	wire [7:0] p1_run_oe = {3'h7, {`RPMPE_ANA_PINS{~adc_enable}}};
	// RULE17 pwm pin shows latch when pwm is stopped
	wire pwm_pin = (pwm_sel & ~in_lowpwr) ? pwm_value : port0_latch[`RPMPE_PWM_BIT];
	wire [4:0] p0_run_out = {pwm_pin, port0_latch[3:0]};

	always_comb begin
		st_d = st_q;
		case (st_q)
			rpmpe_pkg::ST_RESET: begin
				if (!rst_s) begin
					st_d = rpmpe_pkg::ST_KEY;
				end
			end
			rpmpe_pkg::ST_KEY: begin
				// RULE2 key complete
				if (last_bit && key_match) begin
					st_d = rpmpe_pkg::ST_PROG;
				// RULE18 mismatch runs normally
				end else if (last_bit) begin
					st_d = rpmpe_pkg::ST_RUN;
				end
			end
			rpmpe_pkg::ST_RUN: begin
				// RULE10 enter after instruction
				if (instr_done && pdown_req) begin
					st_d = rpmpe_pkg::ST_PDOWN;
				end else if (instr_done && idle_req) begin
					st_d = rpmpe_pkg::ST_IDLE;
				end
			end
			rpmpe_pkg::ST_IDLE: begin
				// RULE13 interrupt wake
				if (irq_wake) begin
					st_d = rpmpe_pkg::ST_RUN;
				end
			end
			default: begin
				st_d = st_q;
			end
		endcase
		// RULE13 RULE16 reset always wins
		if (rst_fire) begin
			st_d = rpmpe_pkg::ST_RESET;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= rpmpe_pkg::ST_RESET;
			rst_cnt_q <= '0;
			xtal_prev_q <= 1'b0;
			vps_prev_q <= 1'b0;
			shift_q <= '0;
			bit_cnt_q <= '0;
		end else begin
			st_q <= st_d;
			xtal_prev_q <= xtal_s;
			vps_prev_q <= vps_s;
			if (!rst_s) begin
				rst_cnt_q <= '0;
			end else if (rst_count_ok && rst_cnt_q != CW'(RST_N - 1)) begin
				rst_cnt_q <= rst_cnt_q + CW'(1);
			end
			// RULE3 bits taken on crystal edges
			if (st_q != rpmpe_pkg::ST_KEY) begin
				bit_cnt_q <= '0;
			end else if (xtal_rise) begin
				shift_q <= key_word;
				bit_cnt_q <= bit_cnt_q + BW'(1);
			end
		end
	end

	// mode outputs
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dev_reset_q <= 1'b1;
			prog_state_q <= 1'b0;
			osc_run_q <= 1'b1;
			clk_half_en_q <= 1'b0;
			cpu_run_q <= 1'b0;
			adc_pwm_run_q <= 1'b0;
			tmr_irq_run_q <= 1'b0;
			vector_go_q <= 1'b0;
		end else begin
			dev_reset_q <= (st_d == rpmpe_pkg::ST_RESET) | (st_d == rpmpe_pkg::ST_KEY);
			prog_state_q <= st_d == rpmpe_pkg::ST_PROG;
			// RULE15 oscillator stops in power-down
			osc_run_q <= st_d != rpmpe_pkg::ST_PDOWN;
			// RULE9 divide by two
			clk_half_en_q <= (st_d != rpmpe_pkg::ST_PDOWN) & ~clk_half_en_q;
			// RULE11 RULE12 idle freezes cpu
			cpu_run_q <= st_d == rpmpe_pkg::ST_RUN;
			adc_pwm_run_q <= st_d == rpmpe_pkg::ST_RUN;
			tmr_irq_run_q <= (st_d == rpmpe_pkg::ST_RUN) | (st_d == rpmpe_pkg::ST_IDLE);
			vector_go_q <= wake_irq;
		end
	end

	// programming access and pins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mem_addr_q <= '0;
			mem_wr_data_q <= '0;
			mem_wr_q <= 1'b0;
			port0_out_q <= '0;
			port0_oe_q <= '0;
			port1_out_q <= '0;
			port1_oe_q <= '0;
			port3_out_q <= '0;
			port3_oe_q <= '0;
		end else begin
			// RULE4 RULE5 address halves
			if (in_prog && !abs_s) begin
				mem_addr_q[`RPMPE_ADDR_LO_BITS-1:0] <= p3_s;
			end else if (in_prog) begin
				mem_addr_q[`RPMPE_ADDR_BITS-1:`RPMPE_ADDR_LO_BITS] <= p3_s[`RPMPE_ADDR_HI_BITS-1:0];
			end
			// RULE6 RULE7 program data on select low
			if (in_prog && !vps_s) begin
				mem_wr_data_q <= p1_s;
			end
			// write as select returns high: just after the fall port 1 still shows verify data
			mem_wr_q <= in_prog & ~vps_prev_q & vps_s;
			if (in_prog) begin
				port0_oe_q <= '0;
				port3_oe_q <= '0;
				// RULE6 verify drives port 1
				port1_out_q <= mem_rd_data;
				port1_oe_q <= {8{vps_s}};
			end else if (st_q == rpmpe_pkg::ST_RESET || st_q == rpmpe_pkg::ST_KEY) begin
				port0_oe_q <= '0;
				port1_oe_q <= '0;
				port3_oe_q <= '0;
			end else begin
				// RULE17 latched data in run, idle and power-down
				port0_out_q <= p0_run_out;
				port0_oe_q <= 5'h1F;
				port1_out_q <= port1_latch;
				port1_oe_q <= p1_run_oe;
				port3_out_q <= port3_latch;
				port3_oe_q <= 8'hFF;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_key_done;
		st_q == rpmpe_pkg::ST_KEY && last_bit && !rst_fire;
	endsequence

	reset_hold_a: assert property ((rst_s && rst_count_ok && rst_cnt_q == CW'(RST_N - 1)) |=> dev_reset_q) // RULE1
		else $error("reset pin held long enough did not reset");
	key_enter_a: assert property ((s_key_done and key_match) |=> prog_state_q && !cpu_run_q) // RULE2
		else $error("matching key did not enter programming");
	key_reject_a: assert property ((s_key_done and !key_match) |=> cpu_run_q && !prog_state_q) // RULE18
		else $error("wrong key did not return to run");
	addr_low_a: assert property ((in_prog && !abs_s && !rst_fire) |=> mem_addr_q[7:0] == $past(p3_s)) // RULE5
		else $error("low address byte not taken");
	verify_drive_a: assert property ((in_prog && vps_s) |=> port1_oe_q == 8'hFF && port1_out_q == $past(mem_rd_data)) // RULE6
		else $error("verify did not drive port 1");
	adc_pins_a: assert property ((st_q == rpmpe_pkg::ST_RUN && adc_enable) |=> port1_oe_q[4:0] == 5'h0) // RULE8
		else $error("analog pin driven while converter on");
	div_two_a: assert property ((clk_half_en_q && osc_run_q) |=> !clk_half_en_q ##1 (clk_half_en_q || !osc_run_q)) // RULE9
		else $error("clock enable not half rate");
	idle_entry_a: assert property ((st_q == rpmpe_pkg::ST_RUN && idle_req && !pdown_req && instr_done && !rst_fire)
		|=> !cpu_run_q && !adc_pwm_run_q && tmr_irq_run_q) // RULE11
		else $error("idle entry wrong");
	no_early_a: assert property ((st_q == rpmpe_pkg::ST_RUN && !instr_done && !rst_fire) |=> cpu_run_q) // RULE10
		else $error("mode entered before instruction end");
	idle_wake_a: assert property (wake_irq |=> cpu_run_q && vector_go_q) // RULE13
		else $error("interrupt did not end idle");
	pdown_stay_a: assert property ((st_q == rpmpe_pkg::ST_PDOWN && !rst_fire) |=> !osc_run_q && !cpu_run_q) // RULE16
		else $error("power-down left without reset");
	pin_hold_a: assert property ((st_q == rpmpe_pkg::ST_IDLE) |=> port3_out_q == $past(port3_latch) && port3_oe_q == 8'hFF) // RULE17
		else $error("port data not held in idle");
	prog_write_a: assert property ((in_prog && !vps_prev_q && vps_s) |=> mem_wr_q && $stable(mem_wr_data_q)) // RULE6
		else $error("program pulse end did not write");
endmodule : rpmpe_ctrl

// ---- rpmpe_cfg.svh ----
// constants for the reset, power mode and programming entry block
`ifndef RPMPE_CFG_SVH
`define RPMPE_CFG_SVH
// oscillator periods in one machine cycle
`define RPMPE_MC_OSC 12
// machine cycles that the reset pin must stay high
`define RPMPE_RST_MC 2
// serial entry key length and value
`define RPMPE_KEY_BITS 10
`define RPMPE_KEY 10'h2A5
// programming address layout
`define RPMPE_ADDR_BITS 11
`define RPMPE_ADDR_LO_BITS 8
`define RPMPE_ADDR_HI_BITS 3
// analog input pins on port 1
`define RPMPE_ANA_PINS 5
// pwm pin position on port 0
`define RPMPE_PWM_BIT 4
`endif

// ---- rpmpe_pkg.sv ----
// types for the reset, power mode and programming entry block
package rpmpe_pkg;
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_KEY = 3'h1,
		ST_RUN = 3'h2,
		ST_IDLE = 3'h3,
		ST_PDOWN = 3'h4,
		ST_PROG = 3'h5
	} rpmpe_state_t;
endpackage : rpmpe_pkg

// ---- rpmpe_sync.sv ----
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module rpmpe_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// pin side and synchronised side
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= pin_in;
			sync_out <= meta_q;
		end
	end
endmodule : rpmpe_sync

// ---- rpmpe_pgm.sv ----
// programmer and reset source model for the rpmpe block
`timescale 1ns/1ps
module rpmpe_pgm (
	// clock
	input wire logic clk_sys,
	// pins driven toward the device
	output logic reset_pin,
	output logic crystal_input,
	output logic address_byte_select,
	output logic verify_program_select,
	output logic [7:0] port1_in,
	output logic [7:0] port3_in,
	// device drive on port 1
	input wire logic [7:0] port1_out_q,
	input wire logic [7:0] port1_oe_q
);
	logic [7:0] p1_drv;
	// undriven port 1 bits take the programmer drive p1_drv
	assign port1_in = (port1_oe_q & port1_out_q) | (~port1_oe_q & p1_drv);
	initial begin
		reset_pin = 1'b0;
		crystal_input = 1'b0;
		address_byte_select = 1'b0;
		verify_program_select = 1'b1;
		port3_in = 8'hFF;
		p1_drv = 8'hFF;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic pin_reset(input int n);
		reset_pin = 1'b1;
		tick(n);
		reset_pin = 1'b0;
		// let the device reach the key phase before any key bit
		tick(4);
	endtask : pin_reset
	task automatic send_key(input logic [9:0] k);
		for (int i = 0; i < 10; i++) begin
			reset_pin = k[i];
			tick(2);
			crystal_input = 1'b1;
			tick(3);
			crystal_input = 1'b0;
			tick(1);
		end
		reset_pin = 1'b0;
	endtask : send_key
	task automatic set_addr(input logic [10:0] a);
		address_byte_select = 1'b0;
		port3_in = a[7:0];
		tick(4);
		address_byte_select = 1'b1;
		port3_in = {5'h15, a[10:8]};
		tick(4);
	endtask : set_addr
	task automatic set_mode(input logic verify, input logic [7:0] d);
		p1_drv = verify ? 8'hFF : d;
		verify_program_select = verify;
	endtask : set_mode
endmodule : rpmpe_pgm

// ---- rpmpe_ctrl_test.sv ----
// self-checking testbench for rpmpe_ctrl
`timescale 1ns/1ps
`include "rpmpe_cfg.svh"
module rpmpe_ctrl_test;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic reset_pin, crystal_input, address_byte_select, verify_program_select;
	logic [7:0] port1_in, port3_in;
	logic idle_req = 1'b0, pdown_req = 1'b0, instr_done = 1'b0, irq_wake = 1'b0;
	logic adc_enable = 1'b0, pwm_sel = 1'b0, pwm_value = 1'b0;
	logic [4:0] port0_latch = 5'h1A;
	logic [7:0] port1_latch = 8'hC5, port3_latch = 8'h69, mem_rd_data = 8'h3C;
	logic dev_reset_q, prog_state_q, osc_run_q, clk_half_en_q, cpu_run_q, adc_pwm_run_q, tmr_irq_run_q;
	logic vector_go_q, mem_wr_q;
	logic [10:0] mem_addr_q;
	logic [7:0] mem_wr_data_q, port1_out_q, port1_oe_q, port3_out_q, port3_oe_q;
	logic [4:0] port0_out_q, port0_oe_q;
	int num_errors = 0;
	int tests_run = 0;
	always #2.5 clk_sys = ~clk_sys;
	rpmpe_ctrl u_rpmpe_ctrl (.clk_sys, .sys_rst, .reset_pin, .crystal_input, .address_byte_select,
		.verify_program_select, .port1_in, .port3_in, .idle_req, .pdown_req, .instr_done, .irq_wake,
		.adc_enable, .pwm_sel, .pwm_value, .port0_latch, .port1_latch, .port3_latch, .mem_rd_data,
		.dev_reset_q, .prog_state_q, .osc_run_q, .clk_half_en_q, .cpu_run_q, .adc_pwm_run_q,
		.tmr_irq_run_q, .vector_go_q, .mem_addr_q, .mem_wr_data_q, .mem_wr_q, .port0_out_q,
		.port0_oe_q, .port1_out_q, .port1_oe_q, .port3_out_q, .port3_oe_q);
	rpmpe_pgm u_rpmpe_pgm (.clk_sys, .reset_pin, .crystal_input, .address_byte_select,
		.verify_program_select, .port1_in, .port3_in, .port1_out_q, .port1_oe_q);
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d, errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	// bounded wait: 0 programming, 1 running, 2 in reset
	task automatic wait_on(input int sel);
		int i;
		for (i = 0; i < 80; i++) begin
			if ((sel == 0 && prog_state_q === 1'b1) || (sel == 1 && cpu_run_q === 1'b1)) break;
			if (sel == 2 && dev_reset_q === 1'b1) break;
			tick(1);
		end
		if (i == 80) begin
			num_errors++;
			test_done();
		end
	endtask : wait_on
	task automatic t_run;
		int n;
		n = 0;
		u_rpmpe_pgm.send_key(`RPMPE_KEY ^ 10'h001);
		wait_on(1);
		chk(prog_state_q, 1'b0); // wrong key runs
		repeat (10) begin
			tick(1);
			n += clk_half_en_q;
		end
		chk(16'(n), 16'h0005); // half rate
		adc_enable = 1'b1;
		tick(4);
		chk(port1_oe_q[4:0], 5'h00); // analog pins released
		adc_enable = 1'b0;
		tick(2);
		chk(port1_oe_q, 8'hFF); // analog pins driven again
	endtask : t_run
	task automatic t_pulse;
		u_rpmpe_pgm.pin_reset(22);
		tick(6);
		chk(dev_reset_q, 1'b0); // short pulse ignored
		u_rpmpe_pgm.pin_reset(30);
		wait_on(2);
		chk(cpu_run_q, 1'b0); // long pulse resets
	endtask : t_pulse
	task automatic t_idle;
		idle_req = 1'b1;
		pwm_sel = 1'b1;
		tick(3);
		chk(cpu_run_q, 1'b1); // waits for instruction
		chk(port0_out_q, 5'h0A); // pwm pin live while running
		instr_done = 1'b1;
		tick(1);
		instr_done = 1'b0;
		idle_req = 1'b0;
		chk({cpu_run_q, adc_pwm_run_q, tmr_irq_run_q}, 3'b001); // idle units
		tick(3);
		chk({port1_out_q, port3_out_q}, {port1_latch, port3_latch}); // ports hold data
		chk(port0_out_q, port0_latch); // pwm pin latched
		chk({port0_oe_q, port3_oe_q}, {5'h1F, 8'hFF}); // ports keep driving
		irq_wake = 1'b1;
		tick(1);
		irq_wake = 1'b0;
		chk({cpu_run_q, vector_go_q}, 2'b11); // interrupt wakes
		tick(1);
		chk(vector_go_q, 1'b0); // one vector pulse
	endtask : t_idle
	task automatic t_pdown;
		pdown_req = 1'b1;
		instr_done = 1'b1;
		tick(1);
		instr_done = 1'b0;
		pdown_req = 1'b0;
		tick(2);
		chk({osc_run_q, clk_half_en_q, cpu_run_q}, 3'b000); // oscillator stops
		irq_wake = 1'b1;
		tick(4);
		irq_wake = 1'b0;
		chk(cpu_run_q, 1'b0); // interrupt ignored
		chk(port1_out_q, port1_latch); // ports hold data
		u_rpmpe_pgm.pin_reset(30);
		wait_on(2);
		chk(osc_run_q, 1'b1); // reset leaves
	endtask : t_pdown
	task automatic t_prog;
		int n;
		logic [7:0] d;
		n = 0;
		d = 8'h00;
		u_rpmpe_pgm.send_key(`RPMPE_KEY);
		wait_on(0);
		chk(dev_reset_q, 1'b0); // key enters programming
		u_rpmpe_pgm.set_addr(11'h5A3);
		chk(mem_addr_q, 11'h5A3); // address parts
		tick(2);
		chk({port1_oe_q, port1_out_q}, {8'hFF, mem_rd_data}); // verify drives data
		chk({port0_oe_q, port3_oe_q}, 13'h0000); // address port undriven
		u_rpmpe_pgm.set_mode(1'b0, 8'h96);
		repeat (6) begin
			tick(1);
			if (mem_wr_q === 1'b1) begin
				n++;
			end
		end
		chk(port1_oe_q, 8'h00); // port released
		u_rpmpe_pgm.set_mode(1'b1, 8'h00);
		repeat (8) begin
			tick(1);
			if (mem_wr_q === 1'b1) begin
				n++;
				d = mem_wr_data_q;
			end
		end
		chk({8'(n), d}, 16'h0196); // one write taken
		chk(port1_oe_q, 8'hFF); // verify drives again
	endtask : t_prog
	initial begin
		tick(12);
		sys_rst = 1'b0;
		t_run();
		t_pulse();
		t_run();
		t_idle();
		t_pdown();
		t_prog();
		test_done();
	end
endmodule : rpmpe_ctrl_test
